/* File: logic/frb_pkg.sv */
// Constants, types and register map of the motor control readback bank
// Notes on behaviour
// - Beta current: signed Q27 word, amps scale 10/8
// - Alpha voltage: signed Q27, scale 60/sqrt(3)
// - Beta voltage: signed Q27, scale 60/sqrt(3)
// - Flux-axis current: signed Q27, scale 10/8
// - Torque-axis current: signed Q27, scale 10/8
// - Two axis voltages as separate signed words
// - Align current reference: signed Q27, scale 10/8
// - Open-loop speed reference scaled by maximum speed
// - Open-loop current reference: signed Q27, 10/8
// - Closed-loop reference meaning follows control mode
// - Closed-loop flux current reference, signed Q27
// - Closed-loop torque current reference, signed Q27
// - Speed detection state: 16 bits, codes 0..6
// - Start speed: unsigned absolute Q27 word
// - Position detection state: 16 bits, codes 0..C
package frb_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = 14;
  localparam int NUM_SLOTS = 16;
  localparam int SLOT_W = 4;
  localparam int STATE_W = 16;
  localparam int Q_FRAC_BITS = 27;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_BETA_CURRENT = 14'h04de;
  localparam logic [IDX_W-1:0] IDX_ALPHA_VOLTAGE = 14'h04e0;
  localparam logic [IDX_W-1:0] IDX_BETA_VOLTAGE = 14'h04e2;
  localparam logic [IDX_W-1:0] IDX_D_CURRENT = 14'h04ec;
  localparam logic [IDX_W-1:0] IDX_Q_CURRENT = 14'h04ee;
  localparam logic [IDX_W-1:0] IDX_D_VOLTAGE = 14'h04f0;
  localparam logic [IDX_W-1:0] IDX_Q_VOLTAGE = 14'h04f2;
  localparam logic [IDX_W-1:0] IDX_ALIGN_CUR_REF = 14'h052a;
  localparam logic [IDX_W-1:0] IDX_OL_SPEED_REF = 14'h0540;
  localparam logic [IDX_W-1:0] IDX_OL_CUR_REF = 14'h0550;
  localparam logic [IDX_W-1:0] IDX_CL_MAIN_REF = 14'h05d2;
  localparam logic [IDX_W-1:0] IDX_CL_FLUX_REF = 14'h0612;
  localparam logic [IDX_W-1:0] IDX_CL_TORQUE_REF = 14'h0614;
  localparam logic [IDX_W-1:0] IDX_SPEED_DET_STATE = 14'h06ae;
  localparam logic [IDX_W-1:0] IDX_SPEED_DET_SPEED = 14'h06b8;
  localparam logic [IDX_W-1:0] IDX_POS_DET_STATE = 14'h06ea;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 14'h0700;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 14'h0701;
  localparam logic [IDX_W-1:0] IDX_CTRL = 14'h0702;

  // Snapshot memory slots
  localparam logic [SLOT_W-1:0] SLOT_BETA_CURRENT = 4'h0;
  localparam logic [SLOT_W-1:0] SLOT_ALPHA_VOLTAGE = 4'h1;
  localparam logic [SLOT_W-1:0] SLOT_BETA_VOLTAGE = 4'h2;
  localparam logic [SLOT_W-1:0] SLOT_D_CURRENT = 4'h3;
  localparam logic [SLOT_W-1:0] SLOT_Q_CURRENT = 4'h4;
  localparam logic [SLOT_W-1:0] SLOT_D_VOLTAGE = 4'h5;
  localparam logic [SLOT_W-1:0] SLOT_Q_VOLTAGE = 4'h6;
  localparam logic [SLOT_W-1:0] SLOT_ALIGN_CUR_REF = 4'h7;
  localparam logic [SLOT_W-1:0] SLOT_OL_SPEED_REF = 4'h8;
  localparam logic [SLOT_W-1:0] SLOT_OL_CUR_REF = 4'h9;
  localparam logic [SLOT_W-1:0] SLOT_CL_MAIN_REF = 4'ha;
  localparam logic [SLOT_W-1:0] SLOT_CL_FLUX_REF = 4'hb;
  localparam logic [SLOT_W-1:0] SLOT_CL_TORQUE_REF = 4'hc;
  localparam logic [SLOT_W-1:0] SLOT_SPEED_DET_STATE = 4'hd;
  localparam logic [SLOT_W-1:0] SLOT_SPEED_DET_SPEED = 4'he;
  localparam logic [SLOT_W-1:0] SLOT_POS_DET_STATE = 4'hf;

  // Start speed detection state codes
  localparam logic [STATE_W-1:0] SPD_DET_INIT = 16'h0000;
  localparam logic [STATE_W-1:0] SPD_DET_STOP_CHECK = 16'h0001;
  localparam logic [STATE_W-1:0] SPD_DET_ESTIM_INIT = 16'h0002;
  localparam logic [STATE_W-1:0] SPD_DET_RUN_CHECK = 16'h0003;
  localparam logic [STATE_W-1:0] SPD_DET_DIR_CHECK = 16'h0004;
  localparam logic [STATE_W-1:0] SPD_DET_COMPLETE = 16'h0005;
  localparam logic [STATE_W-1:0] SPD_DET_FAULT = 16'h0006;

  // Rotor position detection state codes
  localparam logic [STATE_W-1:0] POS_DET_INIT = 16'h0000;
  localparam logic [STATE_W-1:0] POS_DET_VECTOR_CFG = 16'h0001;
  localparam logic [STATE_W-1:0] POS_DET_RUN = 16'h0002;
  localparam logic [STATE_W-1:0] POS_DET_RISE_CLOCK = 16'h0003;
  localparam logic [STATE_W-1:0] POS_DET_FALL_CLOCK = 16'h0004;
  localparam logic [STATE_W-1:0] POS_DET_DECAY_WAIT = 16'h0005;
  localparam logic [STATE_W-1:0] POS_DET_GET_TIMES = 16'h0006;
  localparam logic [STATE_W-1:0] POS_DET_NEXT_VECTOR = 16'h0007;
  localparam logic [STATE_W-1:0] POS_DET_CALC_SECTOR = 16'h0008;
  localparam logic [STATE_W-1:0] POS_DET_CALC_POSITION = 16'h0009;
  localparam logic [STATE_W-1:0] POS_DET_CALC_ANGLE = 16'h000a;
  localparam logic [STATE_W-1:0] POS_DET_COMPLETE = 16'h000b;
  localparam logic [STATE_W-1:0] POS_DET_FAULT = 16'h000c;

  // Interrupt status and mask bits
  localparam int EVT_W = 5;
  localparam int EVT_SNAPSHOT = 0;
  localparam int EVT_SPD_DONE = 1;
  localparam int EVT_SPD_FAULT = 2;
  localparam int EVT_POS_DONE = 3;
  localparam int EVT_POS_FAULT = 4;
  localparam int CTRL_FREEZE = 0;

  localparam logic [DATA_W-1:0] RESET_WORD = 32'h00000000;
  localparam logic [EVT_W-1:0] EVT_NONE = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Read target selected at address decode
  localparam logic [2:0] SEL_SNAP = 3'h0;
  localparam logic [2:0] SEL_STATUS = 3'h1;
  localparam logic [2:0] SEL_MASK = 3'h2;
  localparam logic [2:0] SEL_CTRL = 3'h3;
  localparam logic [2:0] SEL_NONE = 3'h4;

  typedef enum logic [3:0] {
    FRB_RD_IDLE = 4'b0001,
    FRB_RD_MEM = 4'b0010,
    FRB_RD_LOAD = 4'b0100,
    FRB_RD_RESP = 4'b1000
  } frb_rd_t;

endpackage

/* File: logic/frb_snap_mem.sv */
// Snapshot memory holding one coherent copy of all readback words
`timescale 1ns/10ps
module frb_snap_mem (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic wr_en, // Capture all slots at once
  input wire logic [frb_pkg::NUM_SLOTS-1:0][frb_pkg::DATA_W-1:0] wr_words, // New words
  input wire logic rd_en, // Read one slot
  input wire logic [frb_pkg::SLOT_W-1:0] rd_slot, // Slot to read
  output logic [frb_pkg::DATA_W-1:0] rd_data // Registered read data
);
  import frb_pkg::*;

  typedef struct packed {
    logic [NUM_SLOTS-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] rd_data;
  } frb_mem_state_t;

  frb_mem_state_t r;
  frb_mem_state_t next_r;

  always_comb begin
    next_r = r;
    // Read sees the copy before a capture on the same edge
    if (rd_en) begin
      next_r.rd_data = r.mem[rd_slot];
    end
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (wr_en) begin
        next_r.mem[i] = wr_words[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rd_data = r.rd_data;

endmodule

/* File: logic/frb_bank.sv */
// AXI4-Lite readback bank for the motor control algorithm variables
`timescale 1ns/10ps
module frb_bank (
  input wire logic aclk, // System clock, 100 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [frb_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [frb_pkg::DATA_W-1:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [frb_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [frb_pkg::DATA_W-1:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic alg_update, // Algorithm finished one update
  input wire logic [31:0] alg_beta_current, // Beta-axis current
  input wire logic [31:0] alg_alpha_voltage, // Alpha-axis voltage
  input wire logic [31:0] alg_beta_voltage, // Beta-axis voltage
  input wire logic [31:0] alg_d_current, // Flux-axis current
  input wire logic [31:0] alg_q_current, // Torque-axis current
  input wire logic [31:0] alg_d_voltage, // Flux-axis voltage
  input wire logic [31:0] alg_q_voltage, // Torque-axis voltage
  input wire logic [31:0] alg_align_cur_ref, // Align current reference
  input wire logic [31:0] alg_ol_speed_ref, // Open-loop speed reference
  input wire logic [31:0] alg_ol_cur_ref, // Open-loop current reference
  input wire logic [31:0] alg_cl_main_ref, // Closed-loop main reference
  input wire logic [31:0] alg_cl_flux_ref, // Closed-loop flux reference
  input wire logic [31:0] alg_cl_torque_ref, // Closed-loop torque ref
  input wire logic [15:0] alg_speed_det_state, // Speed detection state
  input wire logic [31:0] alg_speed_det_speed, // Start speed, unsigned
  input wire logic [15:0] alg_pos_det_state, // Position detection state
  output logic irq // Level interrupt, high while enabled event pending
);
  import frb_pkg::*;

  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [IDX_W-1:0] aw_idx;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    frb_rd_t rstate;
    logic arready;
    logic [2:0] ar_sel;
    logic [SLOT_W-1:0] ar_slot;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    logic freeze;
    logic [STATE_W-1:0] spd_prev;
    logic [STATE_W-1:0] pos_prev;
    logic irq;
  } frb_state_t;

  frb_state_t r;
  frb_state_t next_r;
  logic [NUM_SLOTS-1:0][DATA_W-1:0] snap_words;
  logic [DATA_W-1:0] mem_rd_data;
  logic capture;
  logic mem_rd_en;

  // Signed Q27 words pass untouched; the states are zero-extended
  assign snap_words[SLOT_BETA_CURRENT] = alg_beta_current;
  assign snap_words[SLOT_ALPHA_VOLTAGE] = alg_alpha_voltage;
  assign snap_words[SLOT_BETA_VOLTAGE] = alg_beta_voltage;
  assign snap_words[SLOT_D_CURRENT] = alg_d_current;
  assign snap_words[SLOT_Q_CURRENT] = alg_q_current;
  assign snap_words[SLOT_D_VOLTAGE] = alg_d_voltage;
  assign snap_words[SLOT_Q_VOLTAGE] = alg_q_voltage;
  assign snap_words[SLOT_ALIGN_CUR_REF] = alg_align_cur_ref;
  assign snap_words[SLOT_OL_SPEED_REF] = alg_ol_speed_ref;
  assign snap_words[SLOT_OL_CUR_REF] = alg_ol_cur_ref;
  assign snap_words[SLOT_CL_MAIN_REF] = alg_cl_main_ref;
  assign snap_words[SLOT_CL_FLUX_REF] = alg_cl_flux_ref;
  assign snap_words[SLOT_CL_TORQUE_REF] = alg_cl_torque_ref;
  assign snap_words[SLOT_SPEED_DET_STATE] =
    {16'h0000, alg_speed_det_state};
  assign snap_words[SLOT_SPEED_DET_SPEED] = alg_speed_det_speed;
  assign snap_words[SLOT_POS_DET_STATE] =
    {16'h0000, alg_pos_det_state};

  // Freeze lets software read several words from one update
  assign capture = alg_update && !r.freeze;
  assign mem_rd_en = (r.rstate == FRB_RD_MEM) && (r.ar_sel == SEL_SNAP);

  frb_snap_mem u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(capture),
    .wr_words(snap_words),
    .rd_en(mem_rd_en),
    .rd_slot(r.ar_slot),
    .rd_data(mem_rd_data)
  );

  always_comb begin
    logic [IDX_W-1:0] ridx;
    logic [2:0] sel;
    logic [SLOT_W-1:0] slot;
    logic [EVT_W-1:0] set_evt;
    logic [EVT_W-1:0] clr_evt;
    ridx = s_axi_araddr[ADDR_W-1:2];
    sel = SEL_SNAP;
    slot = SLOT_BETA_CURRENT;
    set_evt = EVT_NONE;
    clr_evt = EVT_NONE;
    next_r = r;

    // Read address decode
    if (ridx == IDX_BETA_CURRENT) begin
      slot = SLOT_BETA_CURRENT;
    end else if (ridx == IDX_ALPHA_VOLTAGE) begin
      slot = SLOT_ALPHA_VOLTAGE;
    end else if (ridx == IDX_BETA_VOLTAGE) begin
      slot = SLOT_BETA_VOLTAGE;
    end else if (ridx == IDX_D_CURRENT) begin
      slot = SLOT_D_CURRENT;
    end else if (ridx == IDX_Q_CURRENT) begin
      slot = SLOT_Q_CURRENT;
    end else if (ridx == IDX_D_VOLTAGE) begin
      slot = SLOT_D_VOLTAGE;
    end else if (ridx == IDX_Q_VOLTAGE) begin
      slot = SLOT_Q_VOLTAGE;
    end else if (ridx == IDX_ALIGN_CUR_REF) begin
      slot = SLOT_ALIGN_CUR_REF;
    end else if (ridx == IDX_OL_SPEED_REF) begin
      slot = SLOT_OL_SPEED_REF;
    end else if (ridx == IDX_OL_CUR_REF) begin
      slot = SLOT_OL_CUR_REF;
    end else if (ridx == IDX_CL_MAIN_REF) begin
      slot = SLOT_CL_MAIN_REF;
    end else if (ridx == IDX_CL_FLUX_REF) begin
      slot = SLOT_CL_FLUX_REF;
    end else if (ridx == IDX_CL_TORQUE_REF) begin
      slot = SLOT_CL_TORQUE_REF;
    end else if (ridx == IDX_SPEED_DET_STATE) begin
      slot = SLOT_SPEED_DET_STATE;
    end else if (ridx == IDX_SPEED_DET_SPEED) begin
      slot = SLOT_SPEED_DET_SPEED;
    end else if (ridx == IDX_POS_DET_STATE) begin
      slot = SLOT_POS_DET_STATE;
    end else if (ridx == IDX_IRQ_STATUS) begin
      sel = SEL_STATUS;
    end else if (ridx == IDX_IRQ_MASK) begin
      sel = SEL_MASK;
    end else if (ridx == IDX_CTRL) begin
      sel = SEL_CTRL;
    end else begin
      sel = SEL_NONE;
    end

    // Read channel
    case (r.rstate)
      FRB_RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_r.ar_sel = sel;
          next_r.ar_slot = slot;
          next_r.rstate = FRB_RD_MEM;
        end
      end
      FRB_RD_MEM: begin
        next_r.rstate = FRB_RD_LOAD;
      end
      FRB_RD_LOAD: begin
        next_r.rresp = RESP_OKAY;
        if (r.ar_sel == SEL_SNAP) begin
          next_r.rdata = mem_rd_data;
        end else if (r.ar_sel == SEL_STATUS) begin
          next_r.rdata = {27'h0000000, r.status};
        end else if (r.ar_sel == SEL_MASK) begin
          next_r.rdata = {27'h0000000, r.mask};
        end else if (r.ar_sel == SEL_CTRL) begin
          next_r.rdata = {31'h00000000, r.freeze};
        end else begin
          next_r.rdata = RESET_WORD;
          next_r.rresp = RESP_SLVERR;
        end
        next_r.rvalid = 1'b1;
        next_r.rstate = FRB_RD_RESP;
      end
      FRB_RD_RESP: begin
        if (s_axi_rready) begin
          next_r.rvalid = 1'b0;
          next_r.rstate = FRB_RD_IDLE;
        end
      end
      default: begin
        next_r.rstate = FRB_RD_IDLE;
      end
    endcase
    next_r.arready = (next_r.rstate == FRB_RD_IDLE);

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_held = 1'b1;
      next_r.aw_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_held = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      // Only byte 0 carries writable bits; readback words refuse writes
      if (r.aw_idx == IDX_IRQ_STATUS) begin
        if (r.wstrb[0]) begin
          clr_evt = r.wdata[EVT_W-1:0];
        end
      end else if (r.aw_idx == IDX_IRQ_MASK) begin
        if (r.wstrb[0]) begin
          next_r.mask = r.wdata[EVT_W-1:0];
        end
      end else if (r.aw_idx == IDX_CTRL) begin
        if (r.wstrb[0]) begin
          next_r.freeze = r.wdata[CTRL_FREEZE];
        end
      end else begin
        next_r.bresp = RESP_SLVERR;
      end
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    next_r.awready = !next_r.aw_held && !next_r.bvalid;
    next_r.wready = !next_r.w_held && !next_r.bvalid;

    // Events: snapshot on every capture, the rest on entry to a finishing state of either sequence
    if (capture) begin
      set_evt[EVT_SNAPSHOT] = 1'b1;
      set_evt[EVT_SPD_DONE] = (alg_speed_det_state == SPD_DET_COMPLETE) &&
        (r.spd_prev != SPD_DET_COMPLETE);
      set_evt[EVT_SPD_FAULT] = (alg_speed_det_state == SPD_DET_FAULT) &&
        (r.spd_prev != SPD_DET_FAULT);
      set_evt[EVT_POS_DONE] = (alg_pos_det_state == POS_DET_COMPLETE) &&
        (r.pos_prev != POS_DET_COMPLETE);
      set_evt[EVT_POS_FAULT] = (alg_pos_det_state == POS_DET_FAULT) &&
        (r.pos_prev != POS_DET_FAULT);
      next_r.spd_prev = alg_speed_det_state;
      next_r.pos_prev = alg_pos_det_state;
    end
    // A new event beats a clear in the same cycle
    next_r.status = (r.status & ~clr_evt) | set_evt;
    next_r.irq = |(next_r.status & next_r.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.rstate <= FRB_RD_IDLE;
      r.spd_prev <= SPD_DET_INIT;
      r.pos_prev <= POS_DET_INIT;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign irq = r.irq;

  // Helper copy of the last captured snapshot, read only by checks
  logic [NUM_SLOTS-1:0][DATA_W-1:0] chk_copy;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chk_copy <= '0;
    end else if (capture) begin
      chk_copy <= snap_words;
    end
  end

  default clocking chk_clk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_word(logic [SLOT_W-1:0] s);
    $rose(r.rvalid) && r.ar_sel == SEL_SNAP && r.ar_slot == s
      |-> s_axi_rdata == $past(chk_copy[s], 2);
  endproperty

  chk_beta_current_word: assert property (p_word(SLOT_BETA_CURRENT))
    else $error("beta current read differs from snapshot");
  chk_alpha_voltage_word: assert property (p_word(SLOT_ALPHA_VOLTAGE))
    else $error("alpha voltage read differs from snapshot");
  chk_torque_current_word: assert property (p_word(SLOT_Q_CURRENT))
    else $error("torque current read differs from snapshot");
  chk_main_ref_word: assert property (p_word(SLOT_CL_MAIN_REF))
    else $error("closed-loop reference read differs from snapshot");
  chk_speed_state_word: assert property (
    $rose(r.rvalid) && r.ar_sel == SEL_SNAP &&
    r.ar_slot == SLOT_SPEED_DET_STATE |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("speed detection state upper half not zero");
  chk_pos_done_event: assert property (
    capture && alg_pos_det_state == POS_DET_COMPLETE &&
    r.pos_prev != POS_DET_COMPLETE |=> r.status[EVT_POS_DONE])
    else $error("position detection done event lost");
  chk_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 !s_axi_rvalid
    ##1 s_axi_rvalid)
    else $error("read answer not on third cycle");
  chk_freeze_holds: assert property (
    r.freeze && alg_update |=> $stable(chk_copy))
    else $error("snapshot changed while frozen");
  chk_irq_level: assert property (
    irq == |($past(next_r.status) & $past(next_r.mask)))
    else $error("interrupt level does not follow status and mask");
  chk_set_wins: assert property (
    capture && r.bvalid == 1'b0 && r.aw_held && r.w_held &&
    r.aw_idx == IDX_IRQ_STATUS |=> r.status[EVT_SNAPSHOT])
    else $error("snapshot event lost to a clear");

  cov_snap_read: cover property (
    s_axi_rvalid && s_axi_rready && r.ar_sel == SEL_SNAP);
  cov_status_clear: cover property (
    s_axi_bvalid && s_axi_bready && r.status == EVT_NONE);
  cov_irq_rise: cover property ($rose(irq));
  cov_bad_addr: cover property (
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule

/* File: bench/frb_bank_test.sv */
// Self-checking bench for the motor control readback bank
`timescale 1ns/10ps
module frb_bank_test;
  import frb_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic alg_update = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] w [16] = '{default: 32'h00000000};
  logic [31:0] s [16];
  logic [13:0] idx [16];
  logic [31:0] seed = 32'h7e4c;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  always #5 aclk = ~aclk;

  frb_bank DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .alg_update(alg_update),
    .alg_beta_current(w[0]), .alg_alpha_voltage(w[1]),
    .alg_beta_voltage(w[2]), .alg_d_current(w[3]), .alg_q_current(w[4]),
    .alg_d_voltage(w[5]), .alg_q_voltage(w[6]), .alg_align_cur_ref(w[7]),
    .alg_ol_speed_ref(w[8]), .alg_ol_cur_ref(w[9]), .alg_cl_main_ref(w[10]),
    .alg_cl_flux_ref(w[11]), .alg_cl_torque_ref(w[12]),
    .alg_speed_det_state(w[13][15:0]), .alg_speed_det_speed(w[14]),
    .alg_pos_det_state(w[15][15:0]), .irq(irq));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [15:0] ba(input logic [13:0] i);
    return {i, 2'b00};
  endfunction

  // The snapshot bit always fires; the others only on entry into a completion or fault code
  function automatic logic [4:0] evt(input logic [15:0] ps, ns, pp, np);
    logic [4:0] e;
    e = 5'h01;
    e[EVT_SPD_DONE] = (ns != ps) && (ns === SPD_DET_COMPLETE);
    e[EVT_SPD_FAULT] = (ns != ps) && (ns === SPD_DET_FAULT);
    e[EVT_POS_DONE] = (np != pp) && (np === POS_DET_COMPLETE);
    e[EVT_POS_FAULT] = (np != pp) && (np === POS_DET_FAULT);
    return e;
  endfunction

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr_chk(input logic [15:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
      if (bvalid && bready) begin
        compare({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        done = 1;
      end
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
      if (rvalid && rready) begin
        compare(rdata, ed);
        compare({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        done = 1;
      end
    end
  endtask

  task automatic pulse_update();
    @(posedge aclk);
    alg_update <= 1'b1;
    @(posedge aclk);
    alg_update <= 1'b0;
  endtask

  // Hang guard, sized well above the few thousand cycles the run needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    logic [15:0] ps;
    logic [15:0] pp;
    logic [4:0] mask;
    logic [4:0] st;
    idx = '{IDX_BETA_CURRENT, IDX_ALPHA_VOLTAGE, IDX_BETA_VOLTAGE,
      IDX_D_CURRENT, IDX_Q_CURRENT, IDX_D_VOLTAGE, IDX_Q_VOLTAGE,
      IDX_ALIGN_CUR_REF, IDX_OL_SPEED_REF, IDX_OL_CUR_REF, IDX_CL_MAIN_REF,
      IDX_CL_FLUX_REF, IDX_CL_TORQUE_REF, IDX_SPEED_DET_STATE,
      IDX_SPEED_DET_SPEED, IDX_POS_DET_STATE};
    ps = 16'h0000;
    pp = 16'h0000;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd_chk(ba(idx[i]), RESET_WORD, RESP_OKAY);
    end
    rd_chk(ba(IDX_IRQ_STATUS), 32'h0, RESP_OKAY);
    for (int n = 0; n < 24; n++) begin
      seed = xs(seed);
      mask = seed[4:0];
      wr_chk(ba(IDX_IRQ_MASK), {27'h0, mask}, RESP_OKAY);
      for (int i = 0; i < 16; i++) begin
        seed = xs(seed);
        w[i] <= seed;
      end
      // Walk every state code first, then random state words
      if (n < 13) begin
        w[13] <= {seed[31:16], 16'(n % 7)};
        w[15] <= {seed[15:0], 16'(n)};
      end
      pulse_update();
      for (int i = 0; i < 16; i++) begin
        s[i] = w[i];
      end
      s[13][31:16] = 16'h0000;
      s[15][31:16] = 16'h0000;
      st = evt(ps, s[13][15:0], pp, s[15][15:0]);
      ps = s[13][15:0];
      pp = s[15][15:0];
      // Inputs move on without a new update: reads must keep the snapshot
      for (int i = 0; i < 16; i++) begin
        seed = xs(seed);
        w[i] <= seed;
      end
      @(posedge aclk);
      compare({31'h0, irq}, {31'h0, |(st & mask)});
      for (int i = 0; i < 16; i++) begin
        rd_chk(ba(idx[i]), s[i], RESP_OKAY);
      end
      rd_chk(ba(IDX_IRQ_STATUS), {27'h0, st}, RESP_OKAY);
      wr_chk(ba(IDX_IRQ_STATUS), 32'h1f, RESP_OKAY);
      rd_chk(ba(IDX_IRQ_STATUS), 32'h0, RESP_OKAY);
    end
    wr_chk(ba(idx[0]), 32'h12345678, RESP_SLVERR);
    rd_chk(ba(idx[0]), s[0], RESP_OKAY);
    rd_chk(16'h0400, 32'h0, RESP_SLVERR);
    wr_chk(ba(IDX_CTRL), 32'h1, RESP_OKAY);
    pulse_update();
    rd_chk(ba(idx[4]), s[4], RESP_OKAY);
    rd_chk(ba(IDX_IRQ_STATUS), 32'h0, RESP_OKAY);
    wr_chk(ba(IDX_CTRL), 32'h0, RESP_OKAY);
    report_and_stop();
  end
endmodule
